//--- rtl/csr_sequencer.sv
// Clock safeguard, backup oscillator switch and reset sequencer
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module csr_sequencer #(
  parameter logic [15:0] LONG_DELAY_TICKS = 16'(csr_pkg::LONG_DELAY_TICKS)
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Options and internal reset sources
  input  wire csr_pkg::csr_opt_t opt,
  input  wire logic              watchdog_rst,
  // Asynchronous inputs
  input  wire logic              main_osc_in,
  input  wire logic              backup_osc_in,
  input  wire logic              reset_pin_in_n,
  input  wire logic              lvd_undervolt,
  // Oscillator control and internal clock
  output logic                   main_osc_en,
  output logic                   backup_osc_en,
  output logic                   int_clk_tick,
  // Reset pin, open drain
  output logic                   reset_pin_out,
  output logic                   reset_pin_oe_n,
  // Reset to the core
  output csr_pkg::csr_rst_t      rst
);

  typedef enum logic [1:0] {CSR_RUN, CSR_HOLD, CSR_DELAY, CSR_FETCH} csr_state_t;

  logic [3:0]  sync1_q;
  logic [3:0]  sync2_q;
  logic [1:0]  prev_q;
  logic        main_rise;
  logic        backup_rise;
  logic        pin_low;
  logic        lvd_act;
  logic        src;
  logic [8:0]  gap_q;
  logic        main_acc;
  logic        main_run_q;
  logic        use_backup_q;
  logic [1:0]  bk_cnt_q;
  logic        tick_q;
  logic        backup_en_q;
  logic        osc_off_eff;
  logic [7:0]  ctrl_q;
  logic        wr_ctrl;
  csr_state_t  state_q;
  logic [15:0] cnt_q;
  logic [15:0] limit;
  logic [3:0]  wdg_cnt_q;
  logic        drive_q;
  csr_pkg::csr_rst_t rst_q;

  // Two-stage synchronisers: main, backup, reset pin, low voltage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 4'h4;
      sync2_q <= 4'h4;
    end else begin
      sync1_q <= {lvd_undervolt, reset_pin_in_n, backup_osc_in, main_osc_in};
      sync2_q <= sync1_q; // RULE22
    end
  end

  // Edge detect on synchronised oscillator levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 2'h0;
    end else begin
      prev_q <= sync2_q[1:0];
    end
  end

  assign main_rise   = sync2_q[0] & ~prev_q[0];
  assign backup_rise = sync2_q[1] & ~prev_q[1];
  assign pin_low     = ~sync2_q[2]; // RULE15
  assign lvd_act     = opt.lvd_enable & sync2_q[3]; // RULE9
  assign src         = pin_low | watchdog_rst | lvd_act; // RULE11

  // Off bit acts only with the safeguard option
  assign osc_off_eff = opt.safeguard_enable_option & ctrl_q[csr_pkg::OSC_OFF_BIT]; // RULE8

  // Spike filter: edges closer than the minimum period are dropped
  assign main_acc = main_rise &
                    (~opt.safeguard_enable_option | gap_q >= csr_pkg::SG_MIN_CYC); // RULE2

  // Cycles since last accepted main edge, saturating at the miss limit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= csr_pkg::MISS_CYC;
    end else if (main_acc) begin
      gap_q <= 9'h001;
    end else if (gap_q != csr_pkg::MISS_CYC) begin
      gap_q <= gap_q + 9'h001;
    end
  end

  // Main oscillator seen running until an edge goes missing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_run_q <= 1'b0;
    end else if (main_acc) begin
      main_run_q <= 1'b1;
    end else if (gap_q == csr_pkg::MISS_CYC) begin
      main_run_q <= 1'b0; // RULE3
    end
  end

  // Source switch on whole edges only; backup after one full period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      use_backup_q <= 1'b0;
      bk_cnt_q     <= 2'h0;
    end else if (!opt.safeguard_enable_option) begin
      use_backup_q <= 1'b0; // RULE1
      bk_cnt_q     <= 2'h0;
    end else if (main_run_q) begin
      bk_cnt_q <= 2'h0;
      if (main_acc) begin
        use_backup_q <= 1'b0; // RULE23
      end
    end else if (!use_backup_q && backup_rise) begin
      if (bk_cnt_q == 2'h1) begin
        use_backup_q <= 1'b1; // RULE3
      end
      bk_cnt_q <= bk_cnt_q + 2'h1;
    end
  end

  // Internal clock tick, same use in run, wait and stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= use_backup_q ? backup_rise : main_acc; // RULE4 RULE23
    end
  end

  // Backup oscillator runs whenever main is off or not yet running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      backup_en_q <= 1'b0;
    end else begin
      backup_en_q <= opt.safeguard_enable_option &
                     (osc_off_eff | ~main_run_q); // RULE5 RULE6 RULE20
    end
  end

  assign int_clk_tick  = tick_q;
  assign backup_osc_en = backup_en_q;
  assign main_osc_en   = ~osc_off_eff; // RULE7

  // Control register; a chip reset restarts the main oscillator
  assign wr_ctrl = psel & penable & pwrite & (paddr == csr_pkg::CONV_CTRL_ADDR);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= csr_pkg::CONV_CTRL_RESET;
    end else if (rst_q.core_reset) begin
      ctrl_q <= csr_pkg::CONV_CTRL_RESET; // RULE18 RULE19
    end else if (wr_ctrl) begin
      ctrl_q <= pwdata[7:0]; // RULE7
    end
  end

  // APB read mux with error on unmapped addresses
  always_comb begin
    prdata  = 32'h0000_0000;
    pslverr = 1'b0;
    if (paddr == csr_pkg::CONV_CTRL_ADDR) begin
      prdata[7:0] = ctrl_q;
    end else if (paddr == csr_pkg::STATUS_ADDR) begin
      prdata[csr_pkg::ST_USE_BACKUP] = use_backup_q;
      prdata[csr_pkg::ST_MAIN_RUN]   = main_run_q;
      prdata[csr_pkg::ST_CORE_RST]   = rst_q.core_reset;
      prdata[csr_pkg::ST_BACKUP_EN]  = backup_en_q;
      prdata[csr_pkg::ST_LVD_ACT]    = lvd_act;
      pslverr = psel & penable & pwrite;
    end else begin
      pslverr = psel & penable;
    end
  end

  assign pready = 1'b1;

  // Delay length selected by option
  assign limit = opt.long_delay ? LONG_DELAY_TICKS : csr_pkg::SHORT_DELAY_TICKS; // RULE12

  // Reset sequencer: hold, delay, vector fetch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= CSR_DELAY;
      cnt_q   <= 16'h0000;
    end else if (src) begin
      state_q <= CSR_HOLD; // RULE17
      cnt_q   <= 16'h0000;
    end else begin
      unique case (state_q)
        CSR_RUN: begin
          cnt_q <= 16'h0000;
        end
        CSR_HOLD: begin
          state_q <= CSR_DELAY; // RULE16
        end
        CSR_DELAY: begin
          if (tick_q) begin
            if (cnt_q == limit - 16'h0001) begin
              state_q <= CSR_FETCH; // RULE12
              cnt_q   <= 16'h0000;
            end else begin
              cnt_q <= cnt_q + 16'h0001;
            end
          end
        end
        CSR_FETCH: begin
          if (tick_q) begin
            if (cnt_q[1:0] == csr_pkg::FETCH_TICKS - 2'h1) begin
              state_q <= CSR_RUN; // RULE12
            end
            cnt_q <= cnt_q + 16'h0001;
          end
        end
      endcase
    end
  end

  // Registered reset outputs to the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_q <= '{core_reset: 1'b1, stack_clear: 1'b1, nmi_mode_set: 1'b1,
                 ports_input: 1'b1, vector_fetch: 1'b0, pc_load: csr_pkg::RESET_VECTOR};
    end else begin
      rst_q.core_reset   <= state_q != CSR_RUN;
      rst_q.stack_clear  <= state_q != CSR_RUN; // RULE13
      rst_q.nmi_mode_set <= state_q != CSR_RUN; // RULE14
      rst_q.ports_input  <= state_q != CSR_RUN; // RULE18 RULE19
      rst_q.vector_fetch <= state_q == CSR_FETCH;
      rst_q.pc_load      <= csr_pkg::RESET_VECTOR; // RULE13
    end
  end

  assign rst = rst_q;

  // Watchdog flags the reset with a brief pin pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdg_cnt_q <= 4'h0;
    end else if (watchdog_rst) begin
      wdg_cnt_q <= csr_pkg::WDG_FLAG_CYC; // RULE21
    end else if (wdg_cnt_q != 4'h0) begin
      wdg_cnt_q <= wdg_cnt_q - 4'h1;
    end
  end

  // Pin pulled low during low-voltage reset and watchdog flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_q <= 1'b0;
    end else begin
      drive_q <= lvd_act | watchdog_rst | (wdg_cnt_q > 4'h1); // RULE10 RULE21
    end
  end

  assign reset_pin_out  = 1'b0;
  assign reset_pin_oe_n = ~drive_q;

  // Helper: cycles since the last tick
  logic [8:0] tick_gap_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_gap_q <= 9'h1FF;
    end else if (tick_q) begin
      tick_gap_q <= 9'h001;
    end else if (tick_gap_q != 9'h1FF) begin
      tick_gap_q <= tick_gap_q + 9'h001;
    end
  end

  sequence s_fetch_last;
    state_q == CSR_FETCH && tick_q && cnt_q[1:0] == 2'h1 && !src;
  endsequence

  sequence s_delay_last;
    state_q == CSR_DELAY && tick_q && cnt_q == limit - 16'h0001 && !src;
  endsequence

  a_osc_off_gate: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    !opt.safeguard_enable_option |-> main_osc_en) else $error("osc off acted without safeguard");

  a_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    tick_q && !use_backup_q && opt.safeguard_enable_option && $past(use_backup_q) == 1'b0
    |-> tick_gap_q >= csr_pkg::SG_MIN_CYC) else $error("tick faster than limit");

  a_backup_stop: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    main_run_q && !osc_off_eff |=> !backup_osc_en) else $error("backup runs with main");

  a_lvd_pin_low: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    lvd_act |=> !reset_pin_oe_n ##1 rst.core_reset) else $error("lvd reset not on pin");

  a_pin_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE17
    pin_low [*2] |=> state_q == CSR_HOLD ##1 rst.core_reset) else $error("pin low not held");

  a_delay_end: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
    s_delay_last |=> state_q == CSR_FETCH && cnt_q == 16'h0000) else $error("delay end wrong");

  a_fetch_two: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
    s_fetch_last |=> state_q == CSR_RUN ##1 !rst.core_reset) else $error("fetch not 2 ticks");

  a_reset_ctx: assert property (@(posedge pclk) disable iff (!presetn) // RULE13 RULE14
    state_q != CSR_RUN |=> rst.stack_clear && rst.nmi_mode_set
    && rst.pc_load == 12'hFFE) else $error("reset context wrong");

  a_wdg_pulse: assert property (@(posedge pclk) disable iff (!presetn) // RULE21
    watchdog_rst ##1 !watchdog_rst [*8] |=> reset_pin_oe_n || $past(lvd_act))
    else $error("watchdog pin pulse too long");

endmodule

//--- rtl/csr_pkg.sv
// Package with constants and carrier types for the clock safeguard reset sequencer
//
// Summary of operation
// (RULE1) Safeguard functions exist only when option enabled
// (RULE2) Drop spike cycles, cap internal clock rate
// (RULE3) Backup takes over one period after miss
// (RULE4) Backup clock runs code and modes unchanged
// (RULE5) Power-on delay counts backup until main starts
// (RULE6) Backup oscillator stops once main runs
// (RULE7) Control bit 2 stops main oscillator
// (RULE8) Oscillator-off bit ignored without safeguard
// (RULE9) Low-voltage detector holds static reset
// (RULE10) Low-voltage reset drives reset pin low
// (RULE11) Reset sources: pin, watchdog, low voltage
// (RULE12) Wait 2048 or 32768 ticks, fetch 2
// (RULE13) Clear stack, load vector 0FFEh
// (RULE14) Reset enters nonmaskable-interrupt context
// (RULE15) Board may pull reset pin any mode
// (RULE16) Short reset pulses stretched into full delay
// (RULE17) Stay in reset while pin low
// (RULE18) Pin reset halts, ports input, restarts oscillator
// (RULE19) Pin reset in stop starts oscillator
// (RULE20) Oscillator-off with safeguard starts backup
// (RULE21) Watchdog reset like pin, brief pin pulse
// (RULE22) Reset pin synchronised before use
// (RULE23) Clock source switch without truncated pulse
package csr_pkg;

  // Bus and register map
  localparam logic [11:0] CONV_CTRL_IDX   = 12'h0D1;
  localparam logic [11:0] CONV_CTRL_ADDR  = 12'h344;
  localparam logic [11:0] STATUS_IDX      = 12'h0D2;
  localparam logic [11:0] STATUS_ADDR     = 12'h348;
  localparam logic [7:0]  CONV_CTRL_RESET = 8'h40;
  localparam int          OSC_OFF_BIT     = 2;

  // Status register fields
  localparam int ST_USE_BACKUP = 0;
  localparam int ST_MAIN_RUN   = 1;
  localparam int ST_CORE_RST   = 2;
  localparam int ST_BACKUP_EN  = 3;
  localparam int ST_LVD_ACT    = 4;

  // Reset vector and delays in internal clock ticks
  localparam logic [11:0] RESET_VECTOR      = 12'hFFE;
  localparam logic [15:0] SHORT_DELAY_TICKS = 16'h0800;
  localparam int          LONG_DELAY_TICKS  = 32768;
  localparam logic [1:0]  FETCH_TICKS       = 2'h2;

  // Timing at a 125 MHz bus clock
  localparam int CLK_PERIOD_PS    = 8000;
  localparam int SG_MIN_PERIOD_PS = 125000;
  localparam int MISS_TIME_PS     = 2000000;
  localparam int WDG_FLAG_PS      = 64000;
  localparam logic [8:0] SG_MIN_CYC =
    9'((SG_MIN_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [8:0] MISS_CYC   = 9'(MISS_TIME_PS / CLK_PERIOD_PS);
  localparam logic [3:0] WDG_FLAG_CYC = 4'(WDG_FLAG_PS / CLK_PERIOD_PS);

  // Configuration options
  typedef struct packed {
    logic safeguard_enable_option;
    logic lvd_enable;
    logic long_delay;
  } csr_opt_t;

  // Reset outputs to the core
  typedef struct packed {
    logic        core_reset;
    logic        stack_clear;
    logic        nmi_mode_set;
    logic        ports_input;
    logic        vector_fetch;
    logic [11:0] pc_load;
  } csr_rst_t;

endpackage

//--- bench/csr_board.sv
// Board model: main and backup oscillator parts, reset pin with pull-up
`timescale 1ns/1ps
module csr_board (
  // Oscillator control
  input  wire logic        main_run,
  input  wire logic [31:0] main_half_ns,
  input  wire logic        backup_osc_en,
  output logic             main_osc_in,
  output logic             backup_osc_in,
  // Reset pin
  input  wire logic        pull_low,
  input  wire logic        reset_pin_out,
  input  wire logic        reset_pin_oe_n,
  output logic             pin_n
);
  initial main_osc_in = 1'b0;
  initial backup_osc_in = 1'b0;

  // Main oscillator stands still while stopped
  always begin
    #(main_half_ns);
    if (main_run) main_osc_in = ~main_osc_in;
  end

  // Backup oscillator runs only while enabled
  always begin
    #500;
    if (backup_osc_en) backup_osc_in = ~backup_osc_in;
  end

  // Pull-up unless the device or the board pulls low
  assign pin_n = !reset_pin_oe_n ? reset_pin_out : (pull_low ? 1'b0 : 1'b1);
endmodule

//--- bench/tb.sv
// Self-checking bench for the clock safeguard reset sequencer
`timescale 1ns/1ps
module tb;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, q;
  csr_pkg::csr_opt_t opt;
  csr_pkg::csr_rst_t rst;
  logic              watchdog_rst, lvd_undervolt, main_osc_in, backup_osc_in, pin_n;
  logic              main_osc_en, backup_osc_en, int_clk_tick, reset_pin_out;
  logic              reset_pin_oe_n, main_run, pull_low, err, fetch_seen;
  int                main_half, fails, samples_checked, cycles, t, n;

  csr_sequencer #(.LONG_DELAY_TICKS(16'h0040)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .opt(opt),
    .watchdog_rst(watchdog_rst), .main_osc_in(main_osc_in), .backup_osc_in(backup_osc_in),
    .reset_pin_in_n(pin_n), .lvd_undervolt(lvd_undervolt), .main_osc_en(main_osc_en),
    .backup_osc_en(backup_osc_en), .int_clk_tick(int_clk_tick),
    .reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n), .rst(rst));

  csr_board i_board (.main_run(main_run & main_osc_en), .main_half_ns(main_half),
    .backup_osc_en(backup_osc_en), .main_osc_in(main_osc_in), .backup_osc_in(backup_osc_in),
    .pull_low(pull_low), .reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n),
    .pin_n(pin_n));

  // Clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 45000) begin
      fails++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checked %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer, waiting for pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // Count ticks until the core leaves reset
  task automatic wait_run(input int t0);
    t = t0; n = 0; fetch_seen = 1'b0;
    while (rst.core_reset !== 1'b0 && n < 12000) begin
      @(negedge pclk);
      n++;
      if (int_clk_tick === 1'b1) t++;
      if (rst.vector_fetch === 1'b1) fetch_seen = 1'b1;
    end
    check("delay_ticks", (t >= 64 && t <= 68), 1);
    check("fetch_seen", fetch_seen, 1);
  endtask

  task automatic cyc(input int c);
    repeat (c) @(negedge pclk);
  endtask

  task automatic t_regs();
    check("pc_vector", rst.pc_load, csr_pkg::RESET_VECTOR);
    check("ctx_set", {rst.stack_clear, rst.nmi_mode_set, rst.ports_input}, 3'h7);
    wait_run(0);
    apb(1'b0, csr_pkg::CONV_CTRL_ADDR, 32'h0);
    check("ctrl_reset", q, 32'h40);
    apb(1'b0, 12'h100, 32'h0);
    check("unmapped_err", err, 1);
    check("unmapped_data", q, 32'h0);
    apb(1'b1, csr_pkg::STATUS_ADDR, 32'hFF);
    check("status_wr", err, 1);
    apb(1'b1, csr_pkg::CONV_CTRL_ADDR, 32'h44);
    apb(1'b0, csr_pkg::CONV_CTRL_ADDR, 32'h0);
    check("ctrl_rw", q, 32'h44);
    cyc(400);
    check("osc_off", {main_osc_en, backup_osc_en}, 2'b01);
    $display("test regs done");
  endtask

  task automatic t_pin();
    pull_low <= 1'b1;
    cyc(4);
    pull_low <= 1'b0;
    cyc(10);
    check("pin_rst", rst.core_reset, 1);
    wait_run(0);
    pull_low <= 1'b1;
    cyc(300);
    check("pin_hold", {rst.core_reset, rst.ports_input, main_osc_en}, 3'h7);
    pull_low <= 1'b0;
    wait_run(0);
    $display("test pin done");
  endtask

  task automatic t_wdg();
    @(posedge pclk);
    watchdog_rst <= 1'b1;
    @(posedge pclk);
    watchdog_rst <= 1'b0;
    n = 0;
    repeat (40) begin
      @(negedge pclk);
      if (pin_n === 1'b0) n++;
    end
    check("wdg_flag", (n > 0 && n <= csr_pkg::WDG_FLAG_CYC + 1), 1);
    check("wdg_rst", rst.core_reset, 1);
    wait_run(0);
    $display("test watchdog done");
  endtask

  task automatic t_lvd();
    lvd_undervolt <= 1'b1;
    cyc(400);
    check("lvd_hold", {rst.core_reset, pin_n}, 2'b10);
    lvd_undervolt <= 1'b0;
    wait_run(0);
    check("lvd_pin_free", pin_n, 1);
    $display("test lvd done");
  endtask

  task automatic t_clk();
    main_run = 1'b0;
    cyc(600);
    check("backup_on", backup_osc_en, 1);
    n = 0;
    repeat (2000) begin
      @(negedge pclk);
      if (int_clk_tick === 1'b1) n++;
    end
    check("backup_ticks", (n > 4), 1);
    apb(1'b0, csr_pkg::STATUS_ADDR, 32'h0);
    check("status_bk", q, (32'h1 << csr_pkg::ST_USE_BACKUP) | (32'h1 << csr_pkg::ST_BACKUP_EN));
    main_run = 1'b1;
    cyc(600);
    check("backup_off", backup_osc_en, 0);
    main_half = 12;
    t = 1000; n = 1000;
    repeat (800) begin
      @(negedge pclk);
      n++;
      if (int_clk_tick === 1'b1) begin
        if (n < t) t = n;
        n = 0;
      end
    end
    check("min_gap", (t >= csr_pkg::SG_MIN_CYC && t < 40), 1);
    main_half = 100;
    $display("test clock done");
  endtask

  task automatic t_boot(input logic sg);
    presetn <= 1'b0;
    opt.safeguard_enable_option <= sg;
    main_run = 1'b0;
    cyc(2);
    presetn <= 1'b1;
    n = 0;
    repeat (600) begin
      @(negedge pclk);
      if (int_clk_tick === 1'b1) n++;
    end
    check("boot_backup", backup_osc_en, sg);
    main_run = 1'b1;
    wait_run(n);
    apb(1'b1, csr_pkg::CONV_CTRL_ADDR, 32'h44);
    cyc(10);
    check("off_effect", main_osc_en, !sg);
    apb(1'b1, csr_pkg::CONV_CTRL_ADDR, 32'h40);
    $display("test boot done");
  endtask

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; opt = 3'h7; watchdog_rst = 1'b0; lvd_undervolt = 1'b0;
    main_run = 1'b1; main_half = 100; pull_low = 1'b0;
    fails = 0; samples_checked = 0; cycles = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    t_regs();
    t_pin();
    t_wdg();
    t_lvd();
    t_clk();
    t_boot(1'b1);
    t_boot(1'b0);
    test_done();
  end
endmodule
